//--- rtl/dar_pkg.sv
package dar_pkg;
  // pin and status word width
  localparam int unsigned WORD_W = 24;
  // pins that exist; 11..23 are reserved
  localparam int unsigned PIN_N = 11;
  // number of multipurpose pins and their mask registers
  localparam int unsigned MP_N = 5;
  // pin index of each multipurpose pin
  localparam int unsigned PIN_MP_A = 0;
  localparam int unsigned PIN_MP_B = 4;
  localparam int unsigned PIN_MP_C = 6;
  localparam int unsigned PIN_MP_D = 7;
  localparam int unsigned PIN_MP_E = 10;
  // strap pin indices
  localparam int unsigned PIN_ADDR_A = 1;
  localparam int unsigned PIN_ADDR_B = 6;
  localparam int unsigned PIN_HSEL_A = 8;
  localparam int unsigned PIN_HSEL_B = 9;
  // status bit positions
  localparam int unsigned ST_RELAY_ONE = 2;
  localparam int unsigned ST_RELAY_TWO = 1;
  // register indices on the register port
  localparam logic [3:0] REG_LEVEL    = 4'h0;
  localparam logic [3:0] REG_DIR      = 4'h1;
  localparam logic [3:0] REG_POL      = 4'h2;
  localparam logic [3:0] REG_MASK_A   = 4'h3;
  localparam logic [3:0] REG_MASK_B   = 4'h4;
  localparam logic [3:0] REG_MASK_C   = 4'h5;
  localparam logic [3:0] REG_MASK_D   = 4'h6;
  localparam logic [3:0] REG_MASK_E   = 4'h7;
  localparam logic [3:0] REG_SET      = 4'h8;
  localparam logic [3:0] REG_CLR      = 4'h9;
  localparam logic [3:0] REG_STATUS   = 4'hA;
  localparam logic [3:0] REG_ON_A     = 4'hB;
  localparam logic [3:0] REG_ON_B     = 4'hC;
  localparam logic [3:0] REG_OFF_A    = 4'hD;
  localparam logic [3:0] REG_OFF_B    = 4'hE;
  localparam logic [3:0] REG_STRAPS   = 4'hF;
  // reset values
  localparam logic [23:0] DIR_RST   = 24'hFFFFFF;
  localparam logic [23:0] ZERO_WORD = 24'h000000;
  localparam logic [10:0] PIN_VALID = 11'h7FF;
  // relay delay step, one high-rate sample
  localparam int unsigned SAMPLE_NS = 250000;
  // host interface modes
  typedef enum logic [1:0] {
    DAR_HOST_SPI  = 2'b00,
    DAR_HOST_UART = 2'b01,
    DAR_HOST_I2C  = 2'b10
  } dar_host_t;
  // relay timer states
  typedef enum logic [1:0] {
    DAR_RLY_IDLE = 2'b00,
    DAR_RLY_WAIT = 2'b01,
    DAR_RLY_PIPE = 2'b10
  } dar_rly_t;
endpackage

//--- rtl/dar_relay_timer.sv
`timescale 1ns/1ns
// delays one relay request to the reference edges, in whole samples
module dar_relay_timer #(
  parameter int unsigned CNT_W = 24
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // sample strobe and reference edges
  input  wire logic             sample_tick,
  input  wire logic             ref_rise,
  input  wire logic             ref_fall,
  // request and delays
  input  wire logic             want_on,
  input  wire logic [CNT_W-1:0] on_delay,
  input  wire logic [CNT_W-1:0] off_delay,
  // relay output state
  output logic                  relay_on
);
  typedef struct packed {
    dar_pkg::dar_rly_t st;       // timer state
    logic [CNT_W-1:0]  cnt;      // samples left
    logic              target;   // level being moved to
    logic              on;       // present relay level
  } dar_rt_state_t;

  dar_rt_state_t s_r;
  dar_rt_state_t s_nxt;

  // a pending change waits for its edge, then counts samples plus one
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      dar_pkg::DAR_RLY_IDLE: begin
        // turn-on starts on rising reference, turn-off on falling
        // the count stops one tick short; the pipe state adds the extra sample,
        // so a delay of d switches d+1 samples after the edge sample
        if (want_on && !s_r.on && ref_rise) begin
          s_nxt.st     = (on_delay == '0) ? dar_pkg::DAR_RLY_PIPE : dar_pkg::DAR_RLY_WAIT;
          s_nxt.cnt    = on_delay - 1'b1;
          s_nxt.target = 1'b1;
        end else if (!want_on && s_r.on && ref_fall) begin
          s_nxt.st     = (off_delay == '0) ? dar_pkg::DAR_RLY_PIPE : dar_pkg::DAR_RLY_WAIT;
          s_nxt.cnt    = off_delay - 1'b1;
          s_nxt.target = 1'b0;
        end
      end
      dar_pkg::DAR_RLY_WAIT: begin
        // request withdrawn mid-count is dropped
        if (want_on != s_r.target) begin
          s_nxt.st = dar_pkg::DAR_RLY_IDLE;
        end else if (sample_tick) begin
          if (s_r.cnt == '0) begin
            s_nxt.st = dar_pkg::DAR_RLY_PIPE;
          end else begin
            s_nxt.cnt = s_r.cnt - 1'b1;
          end
        end
      end
      dar_pkg::DAR_RLY_PIPE: begin
        // extra sample of latency before switching
        if (sample_tick) begin
          s_nxt.on = s_r.target;
          s_nxt.st = dar_pkg::DAR_RLY_IDLE;
        end
      end
      default: begin
        s_nxt.st = dar_pkg::DAR_RLY_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign relay_on = s_r.on;
endmodule

//--- rtl/dar_gpio.sv
`timescale 1ns/1ns
module dar_gpio #(
  parameter int unsigned CLK_HZ = 20000000
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [23:0] reg_wdata,
  output logic      [23:0] reg_rdata,
  // status from measurement logic
  input  wire logic [23:0] status_in,
  input  wire logic        ref_sign,
  // pins
  input  wire logic [10:0] digital_pin_in,
  output logic      [10:0] digital_pin_out,
  output logic      [10:0] digital_pin_oe,
  // sampled straps
  output logic      [1:0]  host_mode,
  output logic      [1:0]  host_address
);
  // clock cycles in one high-rate sample
  localparam int unsigned TICK_CYC = (CLK_HZ / 1000) * (dar_pkg::SAMPLE_NS / 1000) / 1000;
  localparam int unsigned TICK_W = $clog2(TICK_CYC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  // multipurpose pin positions, in mask order
  localparam int unsigned MP_POS [dar_pkg::MP_N] = '{dar_pkg::PIN_MP_A, dar_pkg::PIN_MP_B,
    dar_pkg::PIN_MP_C, dar_pkg::PIN_MP_D, dar_pkg::PIN_MP_E};

  typedef struct packed {
    logic [23:0]      level;     // software output levels
    logic [23:0]      dir;       // one is input
    logic [23:0]      pol;       // one is active high
    logic [4:0][23:0] mask;      // per multipurpose pin
    logic [23:0]      force_set; // self-clearing
    logic [23:0]      force_clr; // self-clearing
    logic [23:0]      status;    // local status copy
    logic [23:0]      on_a;      // relay one turn-on delay
    logic [23:0]      on_b;      // relay two turn-on delay
    logic [23:0]      off_a;     // relay one turn-off delay
    logic [23:0]      off_b;     // relay two turn-off delay
    logic [23:0]      rdata;     // read data
    logic [10:0]      pin_out;   // pin drive
    logic [10:0]      pin_oe;    // pin enable
    logic [TICK_W-1:0] tick_cnt; // sample divider
    logic             tick;      // sample strobe
    logic             ref_d;     // reference last sample
    logic             rise;      // reference rose
    logic             fall;      // reference fell
    logic             in_rst;    // reset just released
    logic [1:0]       mode;      // sampled host mode
    logic [1:0]       addr;      // sampled address
  } dar_state_t;

  dar_state_t s_r;
  dar_state_t s_nxt;

  logic       relay_one_flag;  // relay one timed output
  logic       relay_two_flag;  // relay two timed output
  logic       want_one;        // relay one request
  logic       want_two;        // relay two request
  logic [23:0] cur_status;     // status seen by masks
  logic [4:0] mp_active;       // per multipurpose pin
  logic [10:0] host_owned;     // pins the host port holds

  // relay timers for both relays
  dar_relay_timer #(.CNT_W(24)) u_relay_one (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .sample_tick(s_r.tick),
    .ref_rise   (s_r.rise),
    .ref_fall   (s_r.fall),
    .want_on    (want_one),
    .on_delay   (s_r.on_a),
    .off_delay  (s_r.off_a),
    .relay_on   (relay_one_flag)
  );
  dar_relay_timer #(.CNT_W(24)) u_relay_two (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .sample_tick(s_r.tick),
    .ref_rise   (s_r.rise),
    .ref_fall   (s_r.fall),
    .want_on    (want_two),
    .on_delay   (s_r.on_b),
    .off_delay  (s_r.off_b),
    .relay_on   (relay_two_flag)
  );

  // status word as masks see it: timed relay bits replace raw ones
  always_comb begin
    cur_status = status_in | s_r.status;
    cur_status[dar_pkg::ST_RELAY_ONE] = relay_one_flag;
    cur_status[dar_pkg::ST_RELAY_TWO] = relay_two_flag;
  end

  // relay requests: forced status or masked alarms in the same mask
  always_comb begin
    logic [23:0] other;
    other = '0;
    want_one = s_r.status[dar_pkg::ST_RELAY_ONE];
    want_two = s_r.status[dar_pkg::ST_RELAY_TWO];
    for (int m = 0; m < dar_pkg::MP_N; m++) begin
      other = s_r.mask[m] & status_in;
      other[dar_pkg::ST_RELAY_ONE] = 1'b0;
      other[dar_pkg::ST_RELAY_TWO] = 1'b0;
      if (s_r.mask[m][dar_pkg::ST_RELAY_ONE] && (other != '0)) begin
        want_one = 1'b1;
      end
      if (s_r.mask[m][dar_pkg::ST_RELAY_TWO] && (other != '0)) begin
        want_two = 1'b1;
      end
    end
  end

  // per multipurpose pin activity
  generate
    for (genvar g = 0; g < dar_pkg::MP_N; g++) begin : g_mp
      always_comb begin
        if (s_r.mask[g][dar_pkg::ST_RELAY_ONE] || s_r.mask[g][dar_pkg::ST_RELAY_TWO]) begin
          // only the relay bits steer the pin here
          mp_active[g] = (s_r.mask[g][dar_pkg::ST_RELAY_ONE] && relay_one_flag) ||
                         (s_r.mask[g][dar_pkg::ST_RELAY_TWO] && relay_two_flag);
        end else begin
          mp_active[g] = |(s_r.mask[g] & cur_status);
        end
      end
    end
  endgenerate

  // pins held by the serial host port in the sampled mode
  always_comb begin
    host_owned = '0;
    host_owned[dar_pkg::PIN_HSEL_A] = 1'b1;
    host_owned[dar_pkg::PIN_HSEL_B] = 1'b1;
    host_owned[dar_pkg::PIN_ADDR_A] = 1'b1;
    host_owned[2] = 1'b1;
    host_owned[3] = 1'b1;
    host_owned[5] = 1'b1;
    if (s_r.mode != dar_pkg::DAR_HOST_SPI) begin
      host_owned[dar_pkg::PIN_ADDR_B] = 1'b1;
    end
  end

  // next state of the whole block
  always_comb begin
    logic       act;
    s_nxt = s_r;
    act   = 1'b0;
    // sample strobe and reference edges, once per sample
    s_nxt.tick = (s_r.tick_cnt == TICK_LAST);
    s_nxt.rise = 1'b0;
    s_nxt.fall = 1'b0;
    if (s_r.tick_cnt == TICK_LAST) begin
      s_nxt.tick_cnt = '0;
      s_nxt.ref_d    = ref_sign;
      s_nxt.rise     = ref_sign && !s_r.ref_d;
      s_nxt.fall     = !ref_sign && s_r.ref_d;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
    end
    // straps caught once, first cycle after reset release
    s_nxt.in_rst = 1'b0;
    if (s_r.in_rst) begin
      if (!digital_pin_in[dar_pkg::PIN_HSEL_A]) begin
        s_nxt.mode = dar_pkg::DAR_HOST_SPI;
      end else if (digital_pin_in[dar_pkg::PIN_HSEL_B]) begin
        s_nxt.mode = dar_pkg::DAR_HOST_I2C;
      end else begin
        s_nxt.mode = dar_pkg::DAR_HOST_UART;
      end
      s_nxt.addr = {digital_pin_in[dar_pkg::PIN_ADDR_B], digital_pin_in[dar_pkg::PIN_ADDR_A]};
    end
    // force registers act then return to zero; set wins over clear
    s_nxt.status = (s_r.status & ~s_r.force_clr) | s_r.force_set;
    s_nxt.force_set = '0;
    s_nxt.force_clr = '0;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        dar_pkg::REG_LEVEL:  s_nxt.level = reg_wdata;
        dar_pkg::REG_DIR:    s_nxt.dir   = reg_wdata;
        dar_pkg::REG_POL:    s_nxt.pol   = reg_wdata;
        dar_pkg::REG_MASK_A: s_nxt.mask[0] = reg_wdata;
        dar_pkg::REG_MASK_B: s_nxt.mask[1] = reg_wdata;
        dar_pkg::REG_MASK_C: s_nxt.mask[2] = reg_wdata;
        dar_pkg::REG_MASK_D: s_nxt.mask[3] = reg_wdata;
        dar_pkg::REG_MASK_E: s_nxt.mask[4] = reg_wdata;
        dar_pkg::REG_SET:    s_nxt.force_set = reg_wdata;
        dar_pkg::REG_CLR:    s_nxt.force_clr = reg_wdata;
        dar_pkg::REG_ON_A:   s_nxt.on_a  = reg_wdata;
        dar_pkg::REG_ON_B:   s_nxt.on_b  = reg_wdata;
        dar_pkg::REG_OFF_A:  s_nxt.off_a = reg_wdata;
        dar_pkg::REG_OFF_B:  s_nxt.off_b = reg_wdata;
        default: begin
          // read-only or unmapped: ignored
        end
      endcase
    end
    // read data, registered one cycle later
    case (reg_addr)
      // inputs show pin level, outputs show the written level
      dar_pkg::REG_LEVEL: begin
        s_nxt.rdata = dar_pkg::ZERO_WORD;
        for (int i = 0; i < dar_pkg::PIN_N; i++) begin
          s_nxt.rdata[i] = s_r.dir[i] ? digital_pin_in[i] : s_r.level[i];
        end
      end
      dar_pkg::REG_DIR:    s_nxt.rdata = s_r.dir;
      dar_pkg::REG_POL:    s_nxt.rdata = s_r.pol;
      dar_pkg::REG_MASK_A: s_nxt.rdata = s_r.mask[0];
      dar_pkg::REG_MASK_B: s_nxt.rdata = s_r.mask[1];
      dar_pkg::REG_MASK_C: s_nxt.rdata = s_r.mask[2];
      dar_pkg::REG_MASK_D: s_nxt.rdata = s_r.mask[3];
      dar_pkg::REG_MASK_E: s_nxt.rdata = s_r.mask[4];
      dar_pkg::REG_SET:    s_nxt.rdata = s_r.force_set;
      dar_pkg::REG_CLR:    s_nxt.rdata = s_r.force_clr;
      dar_pkg::REG_STATUS: s_nxt.rdata = cur_status;
      dar_pkg::REG_ON_A:   s_nxt.rdata = s_r.on_a;
      dar_pkg::REG_ON_B:   s_nxt.rdata = s_r.on_b;
      dar_pkg::REG_OFF_A:  s_nxt.rdata = s_r.off_a;
      dar_pkg::REG_OFF_B:  s_nxt.rdata = s_r.off_b;
      default:             s_nxt.rdata = {20'h00000, s_r.addr, s_r.mode};
    endcase
    // pin drive: host-owned pins never driven by this block
    for (int i = 0; i < dar_pkg::PIN_N; i++) begin
      act = !s_r.level[i]; // written zero is the on state
      for (int m = 0; m < dar_pkg::MP_N; m++) begin
        if (MP_POS[m] == i) begin
          act = act || mp_active[m];
        end
      end
      // a shared pin such as the second address strap stays off outside SPI mode
      s_nxt.pin_oe[i]  = !s_r.dir[i] && !host_owned[i];
      s_nxt.pin_out[i] = s_r.pol[i] ? act : !act;
    end
  end

  // one register stage for all state; reset makes pins inputs
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_r        <= '0;
      s_r.dir    <= dar_pkg::DIR_RST;
      s_r.level  <= dar_pkg::DIR_RST;
      s_r.in_rst <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata       = s_r.rdata;
  assign digital_pin_out = s_r.pin_out;
  assign digital_pin_oe  = s_r.pin_oe;
  assign host_mode       = s_r.mode;
  assign host_address    = s_r.addr;
endmodule

//--- testbench/dar_gpio_asserts.sv
`timescale 1ns/1ns
// port-level checks of the pin block
module dar_gpio_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  // status and reference
  input wire logic [23:0] status_in,
  input wire logic        ref_sign,
  // pins
  input wire logic [10:0] digital_pin_in,
  input wire logic [10:0] digital_pin_out,
  input wire logic [10:0] digital_pin_oe,
  // sampled straps
  input wire logic [1:0]  host_mode,
  input wire logic [1:0]  host_address
);
  // edges since reset release, saturating; keeps $past out of reset
  logic [1:0] since_rst_r;
  logic [1:0] since_rst_nxt;
  // next count
  always_comb begin
    since_rst_nxt = (since_rst_r == 2'h3) ? since_rst_r : since_rst_r + 2'h1;
  end
  // count register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      since_rst_r <= 2'h0;
    end else begin
      since_rst_r <= since_rst_nxt;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_oe_reset;
    $rose(rst_b) |-> digital_pin_oe == 11'h000;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("pins driven out of reset");
  property p_host_pins;
    (digital_pin_oe & 11'h32E) == 11'h000;
  endproperty
  a_host_pins: assert property (p_host_pins) else $error("host pin driven");
  property p_pin6_spi;
    digital_pin_oe[6] |-> host_mode == dar_pkg::DAR_HOST_SPI;
  endproperty
  a_pin6_spi: assert property (p_pin6_spi) else $error("address pin driven");
  property p_straps_hold;
    since_rst_r == 2'h3 |-> $stable(host_mode) && $stable(host_address);
  endproperty
  a_straps_hold: assert property (p_straps_hold) else $error("straps resampled");
  property p_strap_decode;
    $rose(rst_b) |=> host_address == {$past(digital_pin_in[6]), $past(digital_pin_in[1])}
      && host_mode == (!$past(digital_pin_in[8]) ? dar_pkg::DAR_HOST_SPI :
      ($past(digital_pin_in[9]) ? dar_pkg::DAR_HOST_I2C : dar_pkg::DAR_HOST_UART));
  endproperty
  a_strap_decode: assert property (p_strap_decode) else $error("strap decode wrong");
  property p_oe_change;
    since_rst_r != 2'h0 && $changed(digital_pin_oe) |->
      $past(reg_wr, 2) && $past(reg_addr, 2) == dar_pkg::REG_DIR;
  endproperty
  a_oe_change: assert property (p_oe_change) else $error("direction moved alone");
  property p_level_read;
    since_rst_r != 2'h0 && $past(reg_addr) == dar_pkg::REG_LEVEL |-> reg_rdata[23:11] == 13'h0
      && ((reg_rdata[10:0] ^ $past(digital_pin_in)) & ~digital_pin_oe & 11'h491) == 11'h000;
  endproperty
  a_level_read: assert property (p_level_read) else $error("input level misread");
  property p_status_read;
    since_rst_r != 2'h0 && $past(reg_addr) == dar_pkg::REG_STATUS |->
      (reg_rdata & $past(status_in) & 24'hFFFFF9) == ($past(status_in) & 24'hFFFFF9);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status bit lost");
  c_release: cover property ($rose(rst_b));
  c_pin_a_out: cover property (digital_pin_oe[0] && !digital_pin_out[0]);
  c_pin6_out: cover property (digital_pin_oe[6]);
endmodule

//--- testbench/dar_pins_model.sv
`timescale 1ns/1ns
// board around the pins: pull-ups, strap resistors, device drive
module dar_pins_model (
  // device side
  input  wire logic [10:0] pin_out,
  input  wire logic [10:0] pin_oe,
  // strap resistors fitted and their levels
  input  wire logic [10:0] strap_en,
  input  wire logic [10:0] strap_lvl,
  // level seen at the pins
  output logic      [10:0] pin_in
);
  // a driving device beats a resistor; bare pins float up
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (strap_en[i] ? strap_lvl[i] : 1'b1);
    end
  end
endmodule

//--- testbench/dar_gpio_test.sv
`timescale 1ns/1ns
// register-port tests of the pin block
module dar_gpio_test;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic        reg_wr = 1'b0;
  logic [23:0] reg_wdata = 24'h000000;
  logic [23:0] reg_rdata;
  logic [23:0] status_in = 24'h000000;
  logic        ref_sign = 1'b0;
  logic [10:0] pin_in, pin_out, pin_oe;
  logic [10:0] strap_en = 11'h000;
  logic [10:0] strap_lvl = 11'h000;
  logic [1:0]  host_mode, host_address;
  int          n_mismatch = 0;
  int          n_checks = 0;
  // multipurpose pin index per mask, strap cases: UART, I2C, SPI
  int          pin_tab [5] = '{0, 4, 6, 7, 10};
  logic [10:0] s_lvl [3] = '{11'h102, 11'h340, 11'h242};
  logic [1:0]  s_mode [3] = '{2'h1, 2'h2, 2'h0};
  logic [1:0]  s_addr [3] = '{2'h1, 2'h2, 2'h3};
  logic [10:0] s_oe [3] = '{11'h491, 11'h491, 11'h4D1};
  // 20 MHz clock; divider shrunk to 10-cycle samples
  always #25 ref_clk = ~ref_clk;
  dar_gpio #(.CLK_HZ(40000)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .status_in(status_in),
    .ref_sign(ref_sign), .digital_pin_in(pin_in), .digital_pin_out(pin_out),
    .digital_pin_oe(pin_oe), .host_mode(host_mode), .host_address(host_address));
  dar_pins_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .strap_en(strap_en),
    .strap_lvl(strap_lvl), .pin_in(pin_in));
  task automatic chk_word(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pins(input string what, input logic [10:0] exp, input logic [10:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // one write strobe, held across exactly one rising edge
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [23:0] m,
                        input logic [23:0] exp);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    chk_word(what, exp, reg_rdata & m);
  endtask
  // straps fitted only around reset, then pins float
  task automatic do_reset(input logic [10:0] lvl);
    @(negedge ref_clk);
    strap_en = 11'h342;
    strap_lvl = lvl;
    rst_b = 1'b0;
    idle(2);
    rst_b = 1'b1;
    idle(2);
    strap_en = 11'h000;
    idle(3);
  endtask
  // reference edge, then cycles until the pin reaches lvl
  task automatic edge_wait(input logic rise, input int pin, input logic lvl, input int d);
    int n = 0;
    @(negedge ref_clk);
    ref_sign = rise;
    while (pin_out[pin] !== lvl && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    // d+1 samples, up to one sample to see the edge, three register stages
    chk_word("relay_delay_in_window", 24'h1, {23'h0, n >= d * 10 + 13 && n <= d * 10 + 22});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // a hang is cut off well past the expected few hundred cycles
  initial begin
    #1000000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    for (int k = 0; k < 3; k++) begin
      do_reset(s_lvl[k]);
      chk_pins("pin_oe_reset", 11'h000, pin_oe);
      chk_word("host_mode", {22'h0, s_mode[k]}, {22'h0, host_mode});
      chk_word("host_address", {22'h0, s_addr[k]}, {22'h0, host_address});
      rd_chk("strap_read", dar_pkg::REG_STRAPS, 24'hFFFFFF, {20'h00000, s_addr[k], s_mode[k]});
      rd_chk("pin_level_float", dar_pkg::REG_LEVEL, 24'hFFFFFF, 24'h0007FF);
      wr(dar_pkg::REG_DIR, 24'h000000);
      idle(2);
      chk_pins("pin_oe_user", s_oe[k], pin_oe);
    end
    wr(dar_pkg::REG_LEVEL, 24'h000491);
    idle(2);
    chk_pins("pin_drive", 11'h491, pin_out & 11'h4D1);
    wr(dar_pkg::REG_POL, 24'h0000C0);
    idle(2);
    chk_pins("pin_drive_pol", 11'h451, pin_out & 11'h4D1);
    wr(dar_pkg::REG_POL, 24'h000000);
    wr(dar_pkg::REG_LEVEL, 24'h0007FF);
    // each mask fires only its own pin, only on its own bit
    for (int k = 0; k < 5; k++) begin
      wr(dar_pkg::REG_MASK_A + 4'(k), 24'h000001 << (12 + k));
      status_in = 24'h000001 << (13 + k);
      idle(3);
      chk_pins("mask_other_bit", 11'h4D1, pin_out & 11'h4D1);
      status_in = 24'h000001 << (12 + k);
      idle(3);
      chk_pins("mask_hit", 11'h4D1 & ~(11'h001 << pin_tab[k]), pin_out & 11'h4D1);
      status_in = 24'h000000;
      wr(dar_pkg::REG_MASK_A + 4'(k), 24'h000000);
    end
    // relay one on pin a: surge requests it, reference edges time it
    wr(dar_pkg::REG_ON_A, 24'h000002);
    wr(dar_pkg::REG_OFF_A, 24'h000003);
    wr(dar_pkg::REG_MASK_A, 24'h000204);
    status_in = 24'h000200;
    idle(30);
    chk_pins("relay_waits_rise", 11'h001, pin_out & 11'h001);
    edge_wait(1'b1, 0, 1'b0, 2);
    rd_chk("relay_one_status", dar_pkg::REG_STATUS, 24'h000004, 24'h000004);
    status_in = 24'h000000;
    idle(30);
    chk_pins("relay_waits_fall", 11'h000, pin_out & 11'h001);
    edge_wait(1'b0, 0, 1'b1, 3);
    // relay two on pin b by forcing its status bit
    wr(dar_pkg::REG_ON_B, 24'h000001);
    wr(dar_pkg::REG_OFF_B, 24'h000001);
    wr(dar_pkg::REG_MASK_B, 24'h000002);
    wr(dar_pkg::REG_SET, 24'h000002);
    rd_chk("force_set_cleared", dar_pkg::REG_SET, 24'hFFFFFF, 24'h000000);
    edge_wait(1'b1, 4, 1'b0, 1);
    wr(dar_pkg::REG_CLR, 24'h000002);
    edge_wait(1'b0, 4, 1'b1, 1);
    rd_chk("relay_two_cleared", dar_pkg::REG_STATUS, 24'h000002, 24'h000000);
    give_verdict();
  end
endmodule
bind dar_gpio dar_gpio_asserts u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .status_in(status_in),
  .ref_sign(ref_sign), .digital_pin_in(digital_pin_in), .digital_pin_out(digital_pin_out),
  .digital_pin_oe(digital_pin_oe), .host_mode(host_mode), .host_address(host_address));
